// ---- rtl/lmc_pkg.sv ----
// Package with constants, timing figures, states and carriers for the LIN channel mode control.
package lmc_pkg;

   // ==========================================================
   // Timebase
   // ==========================================================
   localparam int CLK_MHZ         = 100;
   localparam int TICK_NS         = 1000;
   localparam int TICK_CYC        = TICK_NS * CLK_MHZ / 1000;

   // ==========================================================
   // Timing figures in microseconds except TXTO_MS in milliseconds, counted in timebase ticks
   // ==========================================================
   localparam int WAKE_FILT_US    = 40;
   localparam int WAKE_ACCEPT_US  = 150;
   localparam int STB_DELAY_MIN_US = 5;
   localparam int STB_DELAY_MAX_US = 40;
   localparam int STB_DELAY_US    = 10;
   localparam int EN_FILT_US      = 20;
   localparam int EN_FILT_MAX_US  = 55;
   localparam int INIT_NORM_US    = 30;
   localparam int INIT_NORM_MAX_US = 75;
   localparam int TXTO_MS         = 25;
   localparam int TXTO_US         = TXTO_MS * 1000;

   localparam int CNT_W           = 16;

   // ==========================================================
   // Channel modes
   // ==========================================================
   typedef enum logic [1:0] {
      LMC_SLEEP   = 2'h0,
      LMC_WAKING  = 2'h1,
      LMC_STANDBY = 2'h3,
      LMC_NORMAL  = 2'h2
   } lmc_mode_t;

   // ==========================================================
   // Carriers
   // ==========================================================
   typedef struct packed {
      logic transmit_in;
      logic channel_enable_in;
      logic bus_in;
   } lmc_pins_in_t;

   typedef struct packed {
      logic bus_drive_low;
      logic receive_out_oe;
      logic tx_ready;
   } lmc_pins_out_t;

   typedef struct packed {
      lmc_mode_t          mode;
      logic [2:0]         en_sync;
      logic [2:0]         tx_sync;
      logic [2:0]         bus_sync;
      logic [CNT_W-1:0]   en_cnt;
      logic [CNT_W-1:0]   wake_cnt;
      logic [CNT_W-1:0]   txto_cnt;
      logic [CNT_W-1:0]   init_cnt;
      logic               tx_blocked;
      logic               tx_path_on;
      lmc_pins_out_t      outs;
   } lmc_chan_t;

endpackage

// ---- rtl/lmc_top.sv ----
// Two-channel LIN mode, wake-up and transmit timing logic.
`timescale 1ns/10ps
module lmc_top
#(
   parameter int N_CH      = 2,
   parameter int TXTO_TICK = lmc_pkg::TXTO_US
)
(
   // Clock and reset
   input  wire logic                core_clk,
   input  wire logic                resetn,
   // Host side pins per channel
   input  wire logic [N_CH-1:0]     transmit_in,
   input  wire logic [N_CH-1:0]     channel_enable_in,
   output logic      [N_CH-1:0]     receive_out_o,
   output logic      [N_CH-1:0]     receive_out_oe,
   output logic      [N_CH-1:0]     tx_ready,
   // Bus side per channel
   input  wire logic [N_CH-1:0]     bus_in,
   output logic      [N_CH-1:0]     bus_o,
   output logic      [N_CH-1:0]     bus_oe
);

   // ==========================================================
   // Elaboration checks
   // ==========================================================
   if (N_CH < 1)
   begin : g_bad_nch
      $error("Channel count must be at least one.");
   end
   if (TXTO_TICK < 2 || TXTO_TICK >= (1 << lmc_pkg::CNT_W))
   begin : g_bad_to
      $error("Transmit timeout does not fit the counter.");
   end

   localparam logic [lmc_pkg::CNT_W-1:0] STB_T   = lmc_pkg::CNT_W'(lmc_pkg::STB_DELAY_US);
   localparam logic [lmc_pkg::CNT_W-1:0] EN_T    = lmc_pkg::CNT_W'(lmc_pkg::EN_FILT_US);
   localparam logic [lmc_pkg::CNT_W-1:0] INIT_T  = lmc_pkg::CNT_W'(lmc_pkg::INIT_NORM_US);
   localparam logic [lmc_pkg::CNT_W-1:0] TO_T    = lmc_pkg::CNT_W'(TXTO_TICK);
   localparam logic [lmc_pkg::CNT_W-1:0] CNT_ONE = lmc_pkg::CNT_W'(1);
   // The first tick may fall just after the dominant edge, so one more tick is counted.
   localparam logic [lmc_pkg::CNT_W-1:0] WAKE_T  = lmc_pkg::CNT_W'(lmc_pkg::WAKE_FILT_US) + CNT_ONE;

   // ==========================================================
   // Shared timebase of one microsecond
   // ==========================================================
   localparam int TB_W = $clog2(lmc_pkg::TICK_CYC + 1);
   localparam logic [TB_W-1:0] TB_LAST = TB_W'(lmc_pkg::TICK_CYC - 1);

   typedef struct packed {
      logic [TB_W-1:0] cnt;
      logic            tick;
   } lmc_tb_t;

   lmc_tb_t tb_r;
   lmc_tb_t tb_nxt;

   always_comb
   begin
      tb_nxt      = tb_r;
      tb_nxt.tick = 1'b0;
      if (tb_r.cnt == TB_LAST)
      begin
         tb_nxt.cnt  = '0;
         tb_nxt.tick = 1'b1;
      end
      else
      begin
         tb_nxt.cnt = tb_r.cnt + TB_W'(1);
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         tb_r <= '0;
      end
      else
      begin
         tb_r <= tb_nxt;
      end
   end

   // ==========================================================
   // Channels
   // ==========================================================
   for (genvar c = 0; c < N_CH; c++)
   begin : g_ch
      lmc_pkg::lmc_chan_t ch_r;
      lmc_pkg::lmc_chan_t ch_nxt;
      logic en_f;
      logic tx_f;
      logic bus_dom;

      always_comb
      begin
         ch_nxt = ch_r;
         ch_nxt.en_sync  = {ch_r.en_sync[1:0], channel_enable_in[c]};
         ch_nxt.tx_sync  = {ch_r.tx_sync[1:0], transmit_in[c]};
         ch_nxt.bus_sync = {ch_r.bus_sync[1:0], bus_in[c]};
         en_f    = ch_r.en_sync[2];
         tx_f    = ch_r.tx_sync[2];
         bus_dom = ~ch_r.bus_sync[2];
         if (ch_r.en_sync[2] == ch_r.en_sync[1])
         begin
            en_f = ch_r.en_sync[1];
         end
         else
         begin
            en_f = ch_r.en_sync[2];
         end

         // Enable filter counts ticks of a stable level that differs from the mode.
         if ((en_f && ch_r.mode != lmc_pkg::LMC_NORMAL) ||
             (!en_f && ch_r.mode == lmc_pkg::LMC_NORMAL))
         begin
            if (tb_r.tick && ch_r.en_cnt != EN_T)
            begin
               ch_nxt.en_cnt = ch_r.en_cnt + CNT_ONE;
            end
         end
         else
         begin
            ch_nxt.en_cnt = '0;
         end

         case (ch_r.mode)
            lmc_pkg::LMC_SLEEP:
            begin
               ch_nxt.outs.receive_out_oe = 1'b0;
               if (bus_dom)
               begin
                  if (tb_r.tick && ch_r.wake_cnt != WAKE_T)
                  begin
                     ch_nxt.wake_cnt = ch_r.wake_cnt + CNT_ONE;
                  end
               end
               else if (ch_r.wake_cnt == WAKE_T)
               begin
                  ch_nxt.mode     = lmc_pkg::LMC_WAKING;
                  ch_nxt.wake_cnt = '0;
               end
               else
               begin
                  ch_nxt.wake_cnt = '0;
               end
            end
            lmc_pkg::LMC_WAKING:
            begin
               if (tb_r.tick)
               begin
                  ch_nxt.wake_cnt = ch_r.wake_cnt + CNT_ONE;
               end
               if (ch_r.wake_cnt == STB_T)
               begin
                  ch_nxt.mode                = lmc_pkg::LMC_STANDBY;
                  ch_nxt.outs.receive_out_oe = 1'b1;
                  ch_nxt.wake_cnt            = '0;
               end
            end
            lmc_pkg::LMC_STANDBY:
            begin
               ch_nxt.outs.receive_out_oe = ~en_f;
            end
            lmc_pkg::LMC_NORMAL:
            begin
               ch_nxt.outs.receive_out_oe = bus_dom;
            end
            default:
            begin
               ch_nxt.mode = lmc_pkg::LMC_SLEEP;
            end
         endcase

         // Mode changes from the enable filter.
         if (ch_r.en_cnt == EN_T)
         begin
            ch_nxt.en_cnt   = '0;
            ch_nxt.wake_cnt = '0;
            if (ch_r.mode == lmc_pkg::LMC_NORMAL)
            begin
               ch_nxt.mode                = lmc_pkg::LMC_SLEEP;
               ch_nxt.outs.receive_out_oe = 1'b0;
            end
            else
            begin
               ch_nxt.mode                = lmc_pkg::LMC_NORMAL;
               ch_nxt.outs.receive_out_oe = 1'b0;
            end
         end

         // Transmit path starts 30 ticks after the enable rise and stops at once on its fall.
         if (!en_f)
         begin
            ch_nxt.tx_path_on = 1'b0;
            ch_nxt.init_cnt   = '0;
         end
         else if (ch_r.init_cnt != INIT_T)
         begin
            if (tb_r.tick)
            begin
               ch_nxt.init_cnt = ch_r.init_cnt + CNT_ONE;
            end
         end
         else
         begin
            ch_nxt.tx_path_on = 1'b1;
         end

         // Dominant timeout and its release.
         if (tx_f)
         begin
            ch_nxt.txto_cnt   = '0;
            ch_nxt.tx_blocked = 1'b0;
         end
         else if (ch_r.txto_cnt == TO_T)
         begin
            ch_nxt.tx_blocked = 1'b1;
         end
         else if (tb_r.tick && ch_r.mode == lmc_pkg::LMC_NORMAL)
         begin
            ch_nxt.txto_cnt = ch_r.txto_cnt + CNT_ONE;
         end

         ch_nxt.outs.tx_ready      = ch_r.tx_path_on && ch_r.mode == lmc_pkg::LMC_NORMAL;
         ch_nxt.outs.bus_drive_low = ch_r.tx_path_on && en_f && !tx_f &&
                                     !ch_nxt.tx_blocked &&
                                     ch_r.mode == lmc_pkg::LMC_NORMAL;
      end

      always_ff @(posedge core_clk)
      begin
         if (!resetn)
         begin
            ch_r          <= '0;
            ch_r.en_sync  <= '0;
            ch_r.tx_sync  <= 3'h7;
            ch_r.bus_sync <= 3'h7;
         end
         else
         begin
            ch_r <= ch_nxt;
         end
      end

      assign receive_out_o[c]  = 1'b0;
      assign receive_out_oe[c] = ch_r.outs.receive_out_oe;
      assign tx_ready[c]       = ch_r.outs.tx_ready;
      assign bus_o[c]          = 1'b0;
      assign bus_oe[c]         = ch_r.outs.bus_drive_low;
   end

endmodule

// ---- verif/lmc_top_assertions.sv ----
// Checker for the mode, wake-up and transmit timing of channel 0.
`timescale 1ns/10ps
module lmc_top_assertions
#(
   parameter int N_CH      = 2,
   parameter int TXTO_TICK = lmc_pkg::TXTO_US
)
(
   // Clock and reset
   input wire logic            core_clk,
   input wire logic            resetn,
   // Pins
   input wire logic [N_CH-1:0] transmit_in,
   input wire logic [N_CH-1:0] channel_enable_in,
   input wire logic [N_CH-1:0] receive_out_o,
   input wire logic [N_CH-1:0] receive_out_oe,
   input wire logic [N_CH-1:0] tx_ready,
   input wire logic [N_CH-1:0] bus_in,
   input wire logic [N_CH-1:0] bus_o,
   input wire logic [N_CH-1:0] bus_oe
);
   // =========
   // Counters
   // =========
   int dom_c, dom_len, rec_c, hi_c, lo_c, txl_c;
   always_ff @(posedge core_clk)
   begin
      dom_c <= bus_in[0] ? 0 : dom_c + 1;
      if (bus_in[0] && dom_c > 0)
         dom_len <= dom_c;
      rec_c <= bus_in[0] ? rec_c + 1 : 0;
      hi_c  <= channel_enable_in[0] ? hi_c + 1 : 0;
      lo_c  <= channel_enable_in[0] ? 0 : lo_c + 1;
      txl_c <= transmit_in[0] ? 0 : txl_c + 1;
   end
   // =========
   // Checks
   // =========
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   tx_follow_a: assert property (transmit_in[0] [*8] |-> !bus_oe[0])
      else $error("bus driven while transmit high");
   en_off_a: assert property (!channel_enable_in[0] [*8] |-> !bus_oe[0])
      else $error("bus driven while enable low");
   rx_dom_a: assert property ((tx_ready[0] && channel_enable_in[0] && !bus_in[0]) [*8]
      |-> receive_out_oe[0]) else $error("dominant not shown on receive");
   rx_rel_a: assert property ((channel_enable_in[0] && bus_in[0]) [*8]
      |-> !receive_out_oe[0]) else $error("receive not released");
   rdy_time_a: assert property ($rose(tx_ready[0]) |-> hi_c >= 1500 && hi_c <= 7500)
      else $error("ready time out of range");
   stb_delay_a: assert property ($rose(receive_out_oe[0]) && lo_c > 6000
      |-> rec_c >= 500 && rec_c <= 4010) else $error("standby delay out of range");
   wake_len_a: assert property ($rose(receive_out_oe[0]) && lo_c > 6000
      |-> dom_len >= 4000) else $error("wake on short dominant");
   wake_acc_a: assert property (rec_c == 4100 && dom_len >= 15000 && lo_c > 25000
      |-> receive_out_oe[0]) else $error("long dominant did not wake");
   txto_lim_a: assert property (bus_oe[0] |-> txl_c <= TXTO_TICK * 100 + 10)
      else $error("transmit timeout missed");
   cover property ($rose(receive_out_oe[0]) && lo_c > 6000);
   cover property ($rose(tx_ready[0]));
   cover property ($fell(bus_oe[0]) && !transmit_in[0]);
endmodule

bind lmc_top lmc_top_assertions #(.N_CH(N_CH), .TXTO_TICK(TXTO_TICK)) u_lmc_top_assertions
   (.core_clk(core_clk), .resetn(resetn), .transmit_in(transmit_in),
    .channel_enable_in(channel_enable_in), .receive_out_o(receive_out_o),
    .receive_out_oe(receive_out_oe), .tx_ready(tx_ready), .bus_in(bus_in),
    .bus_o(bus_o), .bus_oe(bus_oe));

// ---- verif/lmc_host_model.sv ----
// Host controller and single-wire bus model for both channels.
`timescale 1ns/10ps
module lmc_host_model
(
   // Clock
   input wire logic       core_clk,
   // Host pins
   output logic [1:0]     transmit_in,
   output logic [1:0]     channel_enable_in,
   input wire logic [1:0] receive_out_oe,
   output logic [1:0]     wake_seen,
   // Bus
   input wire logic [1:0] bus_oe,
   output logic [1:0]     bus_in
);
   logic [1:0] remote_dom;
   initial
   begin
      transmit_in = 2'h3;
      channel_enable_in = 2'h0;
      remote_dom = 2'h0;
   end
   // The bus is pulled recessive unless some node drives it dominant.
   assign bus_in = ~(bus_oe | remote_dom);
   // A low receive pin with enable low is taken as a wake-up request.
   assign wake_seen = receive_out_oe & ~channel_enable_in;
   // Callers hold each enable level at least 55 us.
   task automatic set_en(input int ch, input logic v);
      @(posedge core_clk);
      channel_enable_in[ch] <= v;
   endtask
endmodule

// ---- verif/lmc_top_tb.sv ----
// Self-checking bench for the two-channel LIN mode and timing logic.
`timescale 1ns/10ps
`define CHK(a, b) \
   begin \
      checks++; \
      if ((a) !== (b)) \
      begin \
         n_errors++; \
         $display("[FAIL] %0t got %h exp %h", $time, a, b); \
      end \
   end
module lmc_top_tb;
   localparam int TXTO = 50;
   logic       core_clk;
   logic       resetn;
   logic [1:0] rx_o, rx_oe, rdy, bus_o, bus_oe, bus_in, tx, en, wake;
   int         n_errors, checks, m_mode[2], m_blk[2];
   integer     seed = 32'hCEBE;
   lmc_top #(.N_CH(2), .TXTO_TICK(TXTO)) u_lmc_top (.core_clk(core_clk), .resetn(resetn),
      .transmit_in(tx), .channel_enable_in(en), .receive_out_o(rx_o),
      .receive_out_oe(rx_oe), .tx_ready(rdy), .bus_in(bus_in), .bus_o(bus_o), .bus_oe(bus_oe));
   lmc_host_model u_host (.core_clk(core_clk), .transmit_in(tx), .channel_enable_in(en),
      .receive_out_oe(rx_oe), .wake_seen(wake), .bus_oe(bus_oe), .bus_in(bus_in));
   // =========
   // Tasks
   // =========
   task automatic run(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic dom(input int ch, input int n);
      @(posedge core_clk);
      u_host.remote_dom[ch] <= 1'b1;
      run(n);
      u_host.remote_dom[ch] <= 1'b0;
   endtask
   task automatic check_all();
      #1;
      for (int c = 0; c < 2; c++)
      begin
         `CHK(rx_oe[c], logic'(m_mode[c] == 1 || (m_mode[c] == 2 && !bus_in[c])))
         `CHK(bus_oe[c], logic'(m_mode[c] == 2 && !tx[c] && m_blk[c] == 0))
         `CHK(rdy[c], logic'(m_mode[c] == 2))
         `CHK(rx_o[c], 1'b0)
         `CHK(bus_o[c], 1'b0)
      end
   endtask
   task automatic complete_run();
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // =========
   // Sequence
   // =========
   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   initial
   begin
      run(80000);
      n_errors++;
      complete_run();
   end
   initial
   begin
      resetn <= 1'b0;
      run(4);
      resetn <= 1'b1;
      run(2);
      check_all();
      dom(0, 3000);
      run(5000);
      check_all();
      dom(0, 15000);
      run(4100);
      m_mode[0] = 1;
      check_all();
      `CHK(wake, 2'h1)
      $display("test wake done");
      u_host.set_en(0, 1'b1);
      run(8);
      m_mode[0] = 3;
      check_all();
      run(7600);
      m_mode[0] = 2;
      check_all();
      repeat (16)
      begin
         @(posedge core_clk);
         u_host.transmit_in <= 2'($random(seed));
         run(20);
         check_all();
      end
      $display("test data done");
      @(posedge core_clk);
      u_host.transmit_in <= 2'h2;
      run(TXTO * 50);
      check_all();
      run(TXTO * 50 + 100);
      m_blk[0] = 1;
      check_all();
      run(500);
      check_all();
      @(posedge core_clk);
      u_host.transmit_in <= 2'h3;
      run(20);
      m_blk[0] = 0;
      u_host.transmit_in <= 2'h2;
      run(20);
      check_all();
      $display("test timeout done");
      u_host.set_en(0, 1'b0);
      run(10);
      m_mode[0] = 0;
      check_all();
      run(5600);
      dom(0, 1000);
      check_all();
      $display("test sleep done");
      complete_run();
   end
endmodule
